// ===== rtl/irc_defines.svh
// register offsets, field positions, reset value and codes of the route block
`ifndef IRC_DEFINES_SVH
`define IRC_DEFINES_SVH
`define IRC_NUM_SRC 4
`define IRC_ADR_W 8
`define IRC_ADR_SOFT_ONE_CFG 8'h00
`define IRC_ADR_MGMT_B_CFG 8'h04
`define IRC_ADR_MGMT_A_CFG 8'h08
`define IRC_ADR_SERIAL_PORT_CFG 8'h0c
`define IRC_ADR_EVT_STATUS 8'h10
`define IRC_ADR_EVT_MASK 8'h14
`define IRC_ADR_PENDING 8'h18
`define IRC_BIT_LATCH_SKIP 4
`define IRC_BIT_PULSE_ASSERT 3
`define IRC_BIT_TRIGGER 2
`define IRC_PICK_HI 1
`define IRC_PICK_LO 0
`define IRC_CFG_RESET 32'h0000_0000
`define IRC_EVT_W 5
`define IRC_EVT_DROP_BIT 4
`define IRC_DEST_CORE_A 2'h0
`define IRC_DEST_CORE_B 2'h1
`define IRC_DEST_EXT 2'h2
`define IRC_DEST_NONE 2'h3
`endif

// ===== rtl/irc_dest_route.sv
// steers delivered levels to the three destination lines
`timescale 1ns/10ps
`include "irc_defines.svh"
module irc_dest_route (
	// inputs
	input wire logic [3:0] lvl_i,
	input wire irc_pkg::irc_cfg_t [3:0] cfg_i,
	// lines
	output irc_pkg::irc_lines_t lines_o
);
	always_comb begin
		lines_o.line_a = |(lvl_i & irc_pkg::irc_pick_vec(cfg_i, `IRC_DEST_CORE_A));
		lines_o.line_b = |(lvl_i & irc_pkg::irc_pick_vec(cfg_i, `IRC_DEST_CORE_B));
		lines_o.line_ext = |(lvl_i & irc_pkg::irc_pick_vec(cfg_i, `IRC_DEST_EXT));
		lines_o.dropped = |(lvl_i & irc_pkg::irc_pick_vec(cfg_i, `IRC_DEST_NONE));
	end
endmodule

// ===== rtl/irc_pkg.sv
// types and helper function of the route block
`include "irc_defines.svh"
package irc_pkg;
	typedef struct packed {
		logic latch_skip;
		logic [1:0] dest_pick;
	} irc_cfg_t;

	typedef enum logic [1:0] {
		IRC_BUS_IDLE = 2'b01,
		IRC_BUS_ACK = 2'b10
	} irc_bus_st_t;

	typedef struct packed {
		logic line_a;
		logic line_b;
		logic line_ext;
		logic dropped;
	} irc_lines_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} irc_wb_req_t;

	typedef struct packed {
		irc_bus_st_t bus;
		irc_cfg_t [3:0] cfg;
		logic [3:0] force_p;
		logic [3:0] pend;
		logic [3:0] lvl;
		logic [4:0] status;
		logic [4:0] mask;
		irc_lines_t lines;
		logic irq;
		logic ack;
		logic [31:0] rdat;
	} irc_state_t;

	// sources whose selector holds the given code
	function automatic logic [3:0] irc_pick_vec(input irc_cfg_t [3:0] cfg, input logic [1:0] code);
		logic [3:0] v;
		v = 4'h0;
		for (int i = 0; i < 4; i++) begin
			v[i] = (cfg[i].dest_pick == code);
		end
		return v;
	endfunction
endpackage

// ===== rtl/irc_route_top.sv
// interrupt source routing registers with wishbone slave
//
// Contract
// - bypass passes live source level to destination
// - no bypass: assertion held until cleared
// - force write without bypass gives one assertion, self-clears
// - selector 0/1/2 picks core a/b/external
// - four identical config registers, reset zero
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
`include "irc_defines.svh"
module irc_route_top (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// interrupt sources
	input wire logic soft_one_src_i,
	input wire logic mgmt_b_src_i,
	input wire logic mgmt_a_src_i,
	input wire logic serial_port_src_i,
	// destinations
	output logic core_irq_line_a_o,
	output logic core_irq_line_b_o,
	output logic external_irq_pin_o,
	output logic irq_o
);
	irc_pkg::irc_state_t st_ff;
	irc_pkg::irc_state_t nxt_st;
	irc_pkg::irc_wb_req_t req;
	irc_pkg::irc_lines_t lines;
	logic [3:0] src_vec;
	logic [3:0] wr_cfg;
	logic [3:0] clr_vec;
	logic [3:0] force_vec;
	logic [3:0] nxt_pend;
	logic [3:0] lvl_vec;
	logic [3:0] skip_vec;
	logic [4:0] w1c_vec;
	logic req_go;
	logic wr_go;

	// configuration register offset of a source
	function automatic logic [7:0] cfg_adr(input int idx);
		logic [7:0] a;
		a = `IRC_ADR_SOFT_ONE_CFG;
		case (idx)
			1: a = `IRC_ADR_MGMT_B_CFG;
			2: a = `IRC_ADR_MGMT_A_CFG;
			3: a = `IRC_ADR_SERIAL_PORT_CFG;
			default: a = `IRC_ADR_SOFT_ONE_CFG;
		endcase
		return a;
	endfunction

	// read image of a configuration register
	function automatic logic [31:0] cfg_word(input irc_pkg::irc_cfg_t c);
		logic [31:0] w;
		w = `IRC_CFG_RESET;
		w[`IRC_BIT_LATCH_SKIP] = c.latch_skip;
		w[`IRC_PICK_HI:`IRC_PICK_LO] = c.dest_pick;
		return w;
	endfunction

	// bus request bundle
	assign req.cyc = wb_cyc_i;
	assign req.stb = wb_stb_i;
	assign req.we = wb_we_i;
	assign req.adr = wb_adr_i;
	assign req.sel = wb_sel_i;
	assign req.dat = wb_dat_i;
	assign src_vec = {serial_port_src_i, mgmt_a_src_i, mgmt_b_src_i, soft_one_src_i};

	// write decode, low byte lane only
	assign req_go = (st_ff.bus == irc_pkg::IRC_BUS_IDLE) && req.cyc && req.stb;
	assign wr_go = req_go && req.we && req.sel[0];
	assign clr_vec = (wr_go && req.adr == `IRC_ADR_PENDING) ? req.dat[3:0] : 4'h0;
	assign w1c_vec = (wr_go && req.adr == `IRC_ADR_EVT_STATUS) ? req.dat[4:0] : 5'h00;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wr_cfg[i] = wr_go && (req.adr == cfg_adr(i));
			skip_vec[i] = st_ff.cfg[i].latch_skip;
		end
	end

	// per-source slices
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_src
			irc_src_slice u_slice (
				.latch_skip_i(st_ff.cfg[g].latch_skip),
				.force_i(st_ff.force_p[g]),
				.clr_i(clr_vec[g]),
				.src_i(src_vec[g]),
				.pend_i(st_ff.pend[g]),
				.nxt_pend_o(nxt_pend[g]),
				.lvl_o(lvl_vec[g])
			);
		end
	endgenerate

	irc_dest_route u_route (
		.lvl_i(lvl_vec),
		.cfg_i(st_ff.cfg),
		.lines_o(lines)
	);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.ack = 1'b0;
		force_vec = 4'h0;
		case (st_ff.bus)
			irc_pkg::IRC_BUS_IDLE: begin
				if (req_go) begin
					nxt_st.bus = irc_pkg::IRC_BUS_ACK;
					nxt_st.ack = 1'b1;
					case (req.adr)
						`IRC_ADR_SOFT_ONE_CFG: nxt_st.rdat = cfg_word(st_ff.cfg[0]);
						`IRC_ADR_MGMT_B_CFG: nxt_st.rdat = cfg_word(st_ff.cfg[1]);
						`IRC_ADR_MGMT_A_CFG: nxt_st.rdat = cfg_word(st_ff.cfg[2]);
						`IRC_ADR_SERIAL_PORT_CFG: nxt_st.rdat = cfg_word(st_ff.cfg[3]);
						`IRC_ADR_EVT_STATUS: nxt_st.rdat = {27'h0, st_ff.status};
						`IRC_ADR_EVT_MASK: nxt_st.rdat = {27'h0, st_ff.mask};
						`IRC_ADR_PENDING: nxt_st.rdat = {28'h0, st_ff.pend};
						default: nxt_st.rdat = 32'h0;
					endcase
				end
			end
			irc_pkg::IRC_BUS_ACK: begin
				nxt_st.bus = irc_pkg::IRC_BUS_IDLE;
			end
			default: begin
				nxt_st.bus = irc_pkg::IRC_BUS_IDLE;
			end
		endcase
		for (int i = 0; i < 4; i++) begin
			if (wr_cfg[i]) begin
				nxt_st.cfg[i].latch_skip = req.dat[`IRC_BIT_LATCH_SKIP];
				nxt_st.cfg[i].dest_pick = req.dat[`IRC_PICK_HI:`IRC_PICK_LO];
				force_vec[i] = req.dat[`IRC_BIT_PULSE_ASSERT] & ~req.dat[`IRC_BIT_LATCH_SKIP];
			end
		end
		nxt_st.force_p = force_vec;
		if (wr_go && req.adr == `IRC_ADR_EVT_MASK) begin
			nxt_st.mask = req.dat[4:0];
		end
		nxt_st.pend = nxt_pend;
		nxt_st.lvl = lvl_vec;
		nxt_st.lines = lines;
		// new deliveries set status, set wins
		nxt_st.status = (st_ff.status & ~w1c_vec) | {lines.dropped, lvl_vec & ~st_ff.lvl};
		nxt_st.irq = |(nxt_st.status & nxt_st.mask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
			st_ff.bus <= irc_pkg::IRC_BUS_IDLE;
		end else if (ce_i) begin
			st_ff <= nxt_st;
		end
	end

	assign wb_dat_o = st_ff.rdat;
	assign wb_ack_o = st_ff.ack;
	assign core_irq_line_a_o = st_ff.lines.line_a;
	assign core_irq_line_b_o = st_ff.lines.line_b;
	assign external_irq_pin_o = st_ff.lines.line_ext;
	assign irq_o = st_ff.irq;

	// assertion helpers
	logic [3:0] hold_req;
	logic [3:0] live_skip;
	logic [3:0] pick_a;
	logic [3:0] pick_none;
	logic [11:0] cfg_flat;
	assign hold_req = st_ff.pend & ~skip_vec & ~clr_vec;
	assign live_skip = src_vec & skip_vec;
	assign pick_a = irc_pkg::irc_pick_vec(st_ff.cfg, `IRC_DEST_CORE_A);
	assign pick_none = irc_pkg::irc_pick_vec(st_ff.cfg, `IRC_DEST_NONE);
	assign cfg_flat = st_ff.cfg;
	logic [3:0] pick_b;
	logic [3:0] pick_ext;
	logic [3:0] clr_only;
	logic [3:0] rise_vec;
	assign pick_b = irc_pkg::irc_pick_vec(st_ff.cfg, `IRC_DEST_CORE_B);
	assign pick_ext = irc_pkg::irc_pick_vec(st_ff.cfg, `IRC_DEST_EXT);
	assign clr_only = clr_vec & ~src_vec & ~st_ff.force_p;
	assign rise_vec = lvl_vec & ~st_ff.lvl;

	property p_bypass_follow;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		1'b1 |=> ((st_ff.lvl & $past(skip_vec)) == $past(live_skip));
	endproperty
	a_bypass_follow: assert property (p_bypass_follow) else $error("bypassed level does not follow source");

	property p_sticky_hold;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		(hold_req != 4'h0) |=> (($past(hold_req) & ~st_ff.pend) == 4'h0);
	endproperty
	a_sticky_hold: assert property (p_sticky_hold) else $error("sticky assertion lost without clear");

	property p_bypass_no_latch;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		(skip_vec != 4'h0) |=> ((st_ff.pend & $past(skip_vec)) == 4'h0);
	endproperty
	a_bypass_no_latch: assert property (p_bypass_no_latch) else $error("latch set while bypassed");

	// force pulse lasts one cycle then latches
	sequence s_force_seen;
		(st_ff.force_p & ~skip_vec) != 4'h0;
	endsequence
	sequence s_force_done;
		(st_ff.force_p == 4'h0) && ((st_ff.pend & $past(st_ff.force_p)) == $past(st_ff.force_p))
			##1 ((st_ff.lvl & $past(st_ff.force_p, 2)) == $past(st_ff.force_p, 2));
	endsequence
	property p_force_once;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		s_force_seen |=> s_force_done;
	endproperty
	a_force_once: assert property (p_force_once) else $error("force not a single latched assertion");

	// source with selector zero reaches core line a
	property p_route_a;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		((lvl_vec & pick_a) != 4'h0) |=> core_irq_line_a_o;
	endproperty
	a_route_a: assert property (p_route_a) else $error("core line a not driven for its source");

	// line a quiet when nothing picks it
	property p_route_a_quiet;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		((lvl_vec & pick_a) == 4'h0) |=> !core_irq_line_a_o;
	endproperty
	a_route_a_quiet: assert property (p_route_a_quiet) else $error("core line a driven without source");

	property p_reset_zero;
		@(posedge clk_i)
		rst_i |=> (cfg_flat == 12'h000 && st_ff.force_p == 4'h0 && !wb_ack_o);
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("configuration not zero after reset");

	property p_route_none;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		(lvl_vec != 4'h0 && (lvl_vec & ~pick_none) == 4'h0) |=>
			(!core_irq_line_a_o && !core_irq_line_b_o && !external_irq_pin_o && st_ff.status[`IRC_EVT_DROP_BIT]);
	endproperty
	a_route_none: assert property (p_route_none) else $error("selector three reached a destination");

	// bus answer comes one cycle after request, for one cycle
	property p_ack_once;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		req_go |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("bus answer timing wrong");

	// interrupt output follows unmasked status
	property p_irq_level;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		1'b1 |-> (irq_o == ((st_ff.status & st_ff.mask) != 5'h00));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt output mismatch");

	// source with selector one reaches core line b
	property p_route_b;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		((lvl_vec & pick_b) != 4'h0) |=> core_irq_line_b_o;
	endproperty
	a_route_b: assert property (p_route_b) else $error("core line b not driven for its source");

	// line b quiet when nothing picks it
	property p_route_b_quiet;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		((lvl_vec & pick_b) == 4'h0) |=> !core_irq_line_b_o;
	endproperty
	a_route_b_quiet: assert property (p_route_b_quiet) else $error("core line b driven without source");

	// source with selector two reaches external line
	property p_route_ext;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		((lvl_vec & pick_ext) != 4'h0) |=> external_irq_pin_o;
	endproperty
	a_route_ext: assert property (p_route_ext) else $error("external line not driven for its source");

	// external line quiet when nothing picks it
	property p_route_ext_quiet;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		((lvl_vec & pick_ext) == 4'h0) |=> !external_irq_pin_o;
	endproperty
	a_route_ext_quiet: assert property (p_route_ext_quiet) else $error("external line driven without source");

	// force with bypass gives no pulse
	property p_force_skip_none;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		((wr_cfg != 4'h0) && req.dat[`IRC_BIT_LATCH_SKIP]) |=> (st_ff.force_p == 4'h0);
	endproperty
	a_force_skip_none: assert property (p_force_skip_none) else $error("force pulse under bypass");

	// clear with no new event empties latch
	property p_pend_clear;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		(clr_only != 4'h0) |=> ((st_ff.pend & $past(clr_only)) == 4'h0);
	endproperty
	a_pend_clear: assert property (p_pend_clear) else $error("latch not cleared by write");

	property p_cfg_read;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		(req_go && !req.we && req.adr == `IRC_ADR_SOFT_ONE_CFG) |=>
			(wb_dat_o == {27'h0, $past(st_ff.cfg[0].latch_skip), 2'b00, $past(st_ff.cfg[0].dest_pick)});
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("configuration read image wrong");

	property p_reset_lines;
		@(posedge clk_i)
		rst_i |=> (!core_irq_line_a_o && !core_irq_line_b_o && !external_irq_pin_o && !irq_o);
	endproperty
	a_reset_lines: assert property (p_reset_lines) else $error("line active after reset");

	// delivered rising level sets its status bit
	property p_status_rise;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		(rise_vec != 4'h0) |=> ((st_ff.status[3:0] & $past(rise_vec)) == $past(rise_vec));
	endproperty
	a_status_rise: assert property (p_status_rise) else $error("status bit not set by rising level");

	// mask write stores low bits
	property p_mask_write;
		@(posedge clk_i) disable iff (rst_i || !ce_i)
		(wr_go && req.adr == `IRC_ADR_EVT_MASK) |=> (st_ff.mask == $past(req.dat[4:0]));
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write not stored");
endmodule

// ===== rtl/irc_src_slice.sv
// per-source latching, bypass and force logic
`timescale 1ns/10ps
module irc_src_slice (
	// configuration
	input wire logic latch_skip_i,
	input wire logic force_i,
	input wire logic clr_i,
	// source and held state
	input wire logic src_i,
	input wire logic pend_i,
	// results
	output logic nxt_pend_o,
	output logic lvl_o
);
	always_comb begin
		if (latch_skip_i) begin
			nxt_pend_o = 1'b0;
			lvl_o = src_i;
		end else begin
			nxt_pend_o = (pend_i & ~clr_i) | src_i | force_i;
			lvl_o = pend_i;
		end
	end
endmodule

// ===== verification/irc_core_sink.sv
// model of the cores and external cpu that receive the lines
`timescale 1ns/10ps
module irc_core_sink (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// received lines
	input wire logic line_a_i,
	input wire logic line_b_i,
	input wire logic line_ext_i,
	// count of assertions seen
	output logic [7:0] seen_cnt_o
);
	logic [2:0] prev_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_ff <= 3'h0;
			seen_cnt_o <= 8'h00;
		end else begin
			prev_ff <= {line_a_i, line_b_i, line_ext_i};
			seen_cnt_o <= seen_cnt_o + 8'(($countones({line_a_i, line_b_i, line_ext_i} & ~prev_ff)));
		end
	end
endmodule

// ===== verification/irc_route_top_bench.sv
// self-checking bench of the route block
`timescale 1ns/10ps
module irc_route_top_bench;
	logic clk_i = 0, rst_i = 1, ce = 1, cyc = 0, stb = 0, we = 0, ack, la, lb, le, irq;
	logic [7:0] adr = 8'h00, seen;
	logic [3:0] sel = 4'h0, src = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, rd;
	int error_cnt = 0, compares = 0;
	irc_route_top irc_route_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .soft_one_src_i(src[0]), .mgmt_b_src_i(src[1]),
		.mgmt_a_src_i(src[2]), .serial_port_src_i(src[3]), .core_irq_line_a_o(la),
		.core_irq_line_b_o(lb), .external_irq_pin_o(le), .irq_o(irq));
	irc_core_sink irc_core_sink_i (.clk_i(clk_i), .rst_i(rst_i), .line_a_i(la), .line_b_i(lb),
		.line_ext_i(le), .seen_cnt_o(seen));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic cw(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic t_reset;
		for (int i = 0; i < 4; i++) begin
			wb(1'b0, 8'(i * 4), 32'h0, rd);
			chk(rd, 32'h0);
		end
		wb(1'b1, 8'h1c, 32'h1f, rd);
		wb(1'b0, 8'h1c, 32'h0, rd);
		chk(rd, 32'h0);
		wb(1'b0, 8'h00, 32'h0, rd);
		chk(rd, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_route;
		for (int i = 0; i < 4; i++) begin
			for (int c = 0; c < 4; c++) begin
				wb(1'b1, 8'(i * 4), 32'(5'h10 | c), rd);
				src[i] <= 1'b1;
				cw(3);
				chk({la, lb, le}, (c == 3) ? 32'h0 : 32'(3'h4 >> c));
				src[i] <= 1'b0;
				cw(3);
				chk({la, lb, le}, 32'h0);
			end
			wb(1'b1, 8'(i * 4), 32'h0, rd);
		end
		$display("route test done");
	endtask
	task automatic t_sticky;
		src[2] <= 1'b1;
		cw(1);
		src[2] <= 1'b0;
		cw(8);
		chk(la, 1'b1);
		wb(1'b1, 8'h18, 32'h4, rd);
		cw(3);
		chk(la, 1'b0);
		$display("sticky test done");
	endtask
	task automatic t_force;
		logic [7:0] base;
		base = seen;
		wb(1'b1, 8'h0c, 32'h09, rd);
		cw(4);
		chk(lb, 1'b1);
		wb(1'b0, 8'h0c, 32'h0, rd);
		chk(rd, 32'h1);
		wb(1'b1, 8'h18, 32'h8, rd);
		cw(3);
		chk(lb, 1'b0);
		chk(seen - base, 8'h01);
		wb(1'b1, 8'h04, 32'h12, rd);
		wb(1'b1, 8'h04, 32'h1a, rd);
		cw(4);
		chk(le, 1'b0);
		wb(1'b1, 8'h04, 32'h0, rd);
		wb(1'b1, 8'h0c, 32'h0, rd);
		$display("force test done");
	endtask
	task automatic t_irq;
		wb(1'b1, 8'h10, 32'h1f, rd);
		wb(1'b1, 8'h00, 32'h10, rd);
		src[0] <= 1'b1;
		cw(3);
		chk(irq, 1'b0);
		wb(1'b0, 8'h10, 32'h0, rd);
		chk(rd, 32'h1);
		wb(1'b1, 8'h14, 32'h1, rd);
		wb(1'b0, 8'h14, 32'h0, rd);
		chk(rd, 32'h1);
		cw(2);
		chk(irq, 1'b1);
		src[0] <= 1'b0;
		wb(1'b1, 8'h10, 32'h1, rd);
		cw(2);
		chk(irq, 1'b0);
		$display("interrupt test done");
	endtask
	task automatic t_freeze;
		ce <= 1'b0;
		src[2] <= 1'b1;
		cw(2);
		src[2] <= 1'b0;
		cw(1);
		ce <= 1'b1;
		cw(4);
		chk(la, 1'b0);
		$display("freeze test done");
	endtask
	task automatic t_rerun;
		wb(1'b1, 8'h10, 32'h1f, rd);
		wb(1'b1, 8'h0c, 32'h13, rd);
		src[3] <= 1'b1;
		cw(3);
		chk({la, lb, le}, 32'h0);
		wb(1'b0, 8'h10, 32'h0, rd);
		chk(rd, 32'h18);
		wb(1'b1, 8'h0c, 32'h12, rd);
		cw(3);
		chk(le, 1'b1);
		rst_i <= 1'b1;
		cw(2);
		rst_i <= 1'b0;
		chk({la, lb, le, irq}, 32'h0);
		src[3] <= 1'b0;
		wb(1'b0, 8'h0c, 32'h0, rd);
		chk(rd, 32'h0);
		$display("restart test done");
	endtask
	initial begin
		cw(10);
		rst_i <= 1'b0;
		t_reset();
		t_route();
		t_sticky();
		t_force();
		t_irq();
		t_freeze();
		t_rerun();
		complete_run();
	end
	initial begin
		cw(20000);
		error_cnt++;
		complete_run();
	end
endmodule
